// File: design/indirect_apb_access_bridge_control.sv
`timescale 1ns/100ps
`default_nettype none
module indirect_apb_access_bridge_control
    import indirect_bridge_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire reg_req_s    reg_req,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        strap_mode_pin0,
    output var  tgt_req_s    tgt_req,
    output var  target_e     tgt_select,
    input  wire logic        tgt_done,
    input  wire logic [31:0] tgt_rdata,
    output var  logic        id_ram_start,
    output var  logic        id_ram_clear_go,
    input  wire logic        id_ram_done,
    output var  logic        id_ram_host_access_off,
    output var  logic        cec_timebase_enable,
    output var  logic        cec_timebase_source
);

    typedef enum logic [1:0] {XFER_IDLE, XFER_WAIT} xfer_e;
    typedef enum logic [1:0] {INIT_STRAP, INIT_IDLE, INIT_BUSY} init_e;

    // Address step for the selected target
    function automatic logic [15:0] step_of(input target_e sel);
        return (sel == TGT_RX_CTL) ? STEP_WORD : STEP_BYTE;
    endfunction : step_of

    // Write strobe for one register offset
    function automatic logic reg_hit(input reg_req_s req, input logic [7:0] ofs);
        return req.wr && (req.addr == ofs);
    endfunction : reg_hit

    // Register state
    logic [4:0]   ctl_q, ctl_d;
    logic [15:0]  addr_q, addr_d;
    logic [31:0]  data_q, data_d;
    logic [4:0]   brg_q, brg_d;
    xfer_e        xfer_q, xfer_d;
    init_e        init_q, init_d;
    tgt_req_s     req_q, req_d;
    logic         start_q, start_d;
    logic         clr_go_q, clr_go_d;
    logic [7:0]   rdata_q, rdata_d;
    logic         wr_hit;
    target_e      sel_now;
    target_e      sel_d;
    logic         ctl_wr;
    logic         brg_wr;

    assign sel_now = target_e'(ctl_q[CTL_SEL_LSB +: 2]);

    // Software strobes that win over the hardware self-clears at read and reload completion
    assign ctl_wr = reg_hit(reg_req, OFS_IND_CTL);
    assign brg_wr = reg_hit(reg_req, OFS_BRIDGE);

    // Indirect access port next state
    always_comb begin
        ctl_d  = ctl_q;
        addr_d = addr_q;
        data_d = data_q;
        xfer_d = xfer_q;
        req_d  = req_q;
        req_d.sel = 1'b0;
        wr_hit = 1'b0;
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                OFS_IND_CTL: ctl_d = reg_req.wdata[4:0] & CTL_RW_MASK;
                OFS_ADDR_LO: addr_d[7:0]   = reg_req.wdata;
                OFS_ADDR_HI: addr_d[15:8]  = reg_req.wdata;
                OFS_DATA_B0: data_d[7:0]   = reg_req.wdata;
                OFS_DATA_B1: data_d[15:8]  = reg_req.wdata;
                OFS_DATA_B2: data_d[23:16] = reg_req.wdata;
                OFS_DATA_B3: begin
                    data_d[31:24] = reg_req.wdata;
                    wr_hit = 1'b1;
                end
                default: ;
            endcase
        end
        unique case (xfer_q)
            XFER_IDLE: begin
                if (ctl_q[CTL_ENABLE_BIT] && ctl_q[CTL_READ_BIT]) begin
                    req_d = '{sel: 1'b1, write: 1'b0, addr: addr_q, wdata: data_q};
                    xfer_d = XFER_WAIT;
                end else if (wr_hit && ctl_q[CTL_ENABLE_BIT]
                             && (sel_now == TGT_RX_CTL || sel_now == TGT_ID_RAM)) begin
                    req_d = '{sel: 1'b1, write: 1'b1, addr: addr_q, wdata: data_d};
                    xfer_d = XFER_WAIT;
                end
            end
            XFER_WAIT: begin
                if (tgt_done) begin
                    if (!req_q.write) begin
                        data_d = tgt_rdata;
                        if (!ctl_wr) begin                             // New start wins
                            ctl_d[CTL_READ_BIT] = 1'b0;
                        end
                    end
                    if (ctl_q[CTL_AUTO_BIT]) begin
                        addr_d = addr_q + step_of(sel_now);
                    end
                    xfer_d = XFER_IDLE;
                end
            end
            default: xfer_d = XFER_IDLE;
        endcase
    end

    // Bridge control and ID RAM init next state
    always_comb begin
        brg_d    = brg_q;
        init_d   = init_q;
        start_d  = 1'b0;
        clr_go_d = 1'b0;
        if (brg_wr) begin
            brg_d = (reg_req.wdata[4:0] & BRG_RW_MASK) | (brg_q & ~BRG_RW_MASK);
        end
        unique case (init_q)
            INIT_STRAP: begin
                brg_d[BRG_HOST_OFF_BIT] = strap_mode_pin0;
                init_d = INIT_IDLE;
            end
            INIT_IDLE: begin
                if (brg_d[BRG_RELOAD_BIT]) begin
                    start_d  = 1'b1;
                    clr_go_d = brg_d[BRG_CLEAR_BIT];
                    init_d   = INIT_BUSY;
                end else begin
                    brg_d[BRG_CLEAR_BIT] = 1'b0;
                end
            end
            INIT_BUSY: begin
                if (id_ram_done) begin
                    if (!brg_wr) begin                                 // New request wins
                        brg_d[BRG_RELOAD_BIT] = 1'b0;
                        brg_d[BRG_CLEAR_BIT]  = 1'b0;
                    end
                    init_d = INIT_IDLE;
                end
            end
            default: init_d = INIT_IDLE;
        endcase
    end

    // Register read mux
    always_comb begin
        rdata_d = RESET_BYTE;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                OFS_IND_CTL: rdata_d = {3'h0, ctl_q};
                OFS_ADDR_LO: rdata_d = addr_q[7:0];
                OFS_ADDR_HI: rdata_d = addr_q[15:8];
                OFS_DATA_B0: rdata_d = data_q[7:0];
                OFS_DATA_B1: rdata_d = data_q[15:8];
                OFS_DATA_B2: rdata_d = data_q[23:16];
                OFS_DATA_B3: rdata_d = data_q[31:24];
                OFS_BRIDGE:  rdata_d = {3'h0, brg_q};
                default:     rdata_d = RESET_BYTE;
            endcase
        end
    end

    // Indirect port registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_q    <= '0;
            addr_q   <= '0;
            data_q   <= '0;
            xfer_q   <= XFER_IDLE;
            req_q    <= '0;
        end else begin
            ctl_q    <= ctl_d;
            addr_q   <= addr_d;
            data_q   <= data_d;
            xfer_q   <= xfer_d;
            req_q    <= req_d;
        end
    end

    // Bridge control and ID RAM init registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            brg_q    <= '0;
            init_q   <= INIT_STRAP;
            start_q  <= 1'b0;
            clr_go_q <= 1'b0;
        end else begin
            brg_q    <= brg_d;
            init_q   <= init_d;
            start_q  <= start_d;
            clr_go_q <= clr_go_d;
        end
    end

    // Register read data
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q  <= RESET_BYTE;
        end else begin
            rdata_q  <= rdata_d;
        end
    end

    // Selector copy for the target side
    always_comb begin
        sel_d = sel_now;
    end

    // Outputs straight from flops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tgt_select <= TGT_RX_CTL;
        end else begin
            tgt_select <= sel_d;
        end
    end

    assign tgt_req                = req_q;
    assign reg_rdata              = rdata_q;
    assign id_ram_start           = start_q;
    assign id_ram_clear_go        = clr_go_q;
    assign id_ram_host_access_off = brg_q[BRG_HOST_OFF_BIT];
    assign cec_timebase_enable    = brg_q[BRG_CEC_EN_BIT];
    assign cec_timebase_source    = brg_q[BRG_CEC_SRC_BIT];

endmodule : indirect_apb_access_bridge_control
`default_nettype wire

// File: design/indirect_bridge_pkg.sv
package indirect_bridge_pkg;

    // Register offsets on the serial control bus
    localparam logic [7:0] OFS_IND_CTL   = 8'h48;
    localparam logic [7:0] OFS_ADDR_LO   = 8'h49;
    localparam logic [7:0] OFS_ADDR_HI   = 8'h4a;
    localparam logic [7:0] OFS_DATA_B0   = 8'h4b;
    localparam logic [7:0] OFS_DATA_B1   = 8'h4c;
    localparam logic [7:0] OFS_DATA_B2   = 8'h4d;
    localparam logic [7:0] OFS_DATA_B3   = 8'h4e;
    localparam logic [7:0] OFS_BRIDGE    = 8'h4f;

    // Indirect control field positions
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_READ_BIT   = 1;
    localparam int CTL_AUTO_BIT   = 2;
    localparam int CTL_SEL_LSB    = 3;

    // Bridge control field positions
    localparam int BRG_HOST_OFF_BIT = 0;
    localparam int BRG_RELOAD_BIT   = 1;
    localparam int BRG_CLEAR_BIT    = 2;
    localparam int BRG_CEC_EN_BIT   = 3;
    localparam int BRG_CEC_SRC_BIT  = 4;

    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [15:0] STEP_WORD    = 16'h0004;
    localparam logic [15:0] STEP_BYTE    = 16'h0001;
    localparam logic [4:0]  CTL_RW_MASK  = 5'h1f;
    localparam logic [4:0]  BRG_RW_MASK  = 5'h1e;

    // Target selector encodings
    typedef enum logic [1:0] {
        TGT_RX_CTL  = 2'h0,
        TGT_ID_RAM  = 2'h1,
        TGT_CFG_ROM = 2'h2,
        TGT_DIE_ID  = 2'h3
    } target_e;

    // Register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Internal target request
    typedef struct packed {
        logic       sel;
        logic       write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } tgt_req_s;

endpackage : indirect_bridge_pkg

// File: verification/bridge_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module bridge_chk_sva
    import indirect_bridge_pkg::*;
(
    input wire logic     core_clk,
    input wire logic     rst,
    input wire reg_req_s reg_req,
    input wire tgt_req_s tgt_req,
    input wire target_e  tgt_select,
    input wire logic     id_ram_start,
    input wire logic     id_ram_clear_go,
    input wire logic     cec_timebase_enable,
    input wire logic     cec_timebase_source
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Register write strobes
    wire logic b3_wr = reg_req.wr && reg_req.addr == OFS_DATA_B3;
    wire logic br_wr = reg_req.wr && reg_req.addr == OFS_BRIDGE;
    wire logic ld_wr = br_wr && reg_req.wdata[BRG_RELOAD_BIT];
    wire logic cl_wr = ld_wr && reg_req.wdata[BRG_CLEAR_BIT];
    // Target handshake and bridge control outputs
    property p_one; tgt_req.sel |=> !tgt_req.sel; endproperty
    a_one: assert property (p_one) else $error("request too long");
    property p_wcause; tgt_req.sel && tgt_req.write |-> $past(b3_wr) || $past(b3_wr, 2); endproperty
    a_wcause: assert property (p_wcause) else $error("write without top byte");
    property p_ro; tgt_req.sel && tgt_req.write |-> !tgt_select[1]; endproperty
    a_ro: assert property (p_ro) else $error("write to read-only target");
    property p_en;
        br_wr ##1 !br_wr |=> cec_timebase_enable == $past(reg_req.wdata[BRG_CEC_EN_BIT], 2);
    endproperty
    a_en: assert property (p_en) else $error("timebase enable wrong");
    property p_src;
        br_wr ##1 !br_wr |=> cec_timebase_source == $past(reg_req.wdata[BRG_CEC_SRC_BIT], 2);
    endproperty
    a_src: assert property (p_src) else $error("timebase source wrong");
    property p_start; id_ram_start |-> $past(ld_wr) || $past(ld_wr, 2); endproperty
    a_start: assert property (p_start) else $error("reload without request");
    property p_clr; id_ram_clear_go |-> id_ram_start && ($past(cl_wr) || $past(cl_wr, 2)); endproperty
    a_clr: assert property (p_clr) else $error("clear without both bits");
    property p_pulse; id_ram_start |=> !id_ram_start; endproperty
    a_pulse: assert property (p_pulse) else $error("reload start too long");
endmodule : bridge_chk_sva
bind indirect_apb_access_bridge_control bridge_chk_sva u_chk (.*);
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import indirect_bridge_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        strap_mode_pin0 = 1'b1;
    logic [3:0]  lat = 4'h2;
    reg_req_s    reg_req = '0;
    tgt_req_s    tgt_req;
    target_e     tgt_select;
    logic [7:0]  reg_rdata;
    logic [31:0] tgt_rdata, w;
    logic [15:0] adr;
    logic        tgt_done, id_ram_start, id_ram_clear_go, id_ram_done, clr = 1'b0;
    logic        id_ram_host_access_off, cec_timebase_enable, cec_timebase_source;
    int          n_fail = 0, checks_done = 0, n_req = 0, n0;
    indirect_apb_access_bridge_control dut (.*);
    tgt_model tgt (.*);
    // Clock, request counter and sticky clear pulse flag
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        n_req += int'(tgt_req.sel === 1'b1);
        clr |= id_ram_clear_go === 1'b1;
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // One register access; on a read d is the expected byte
    task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{~r, r, a, r ? 8'h00 : d};
        @(posedge core_clk);
        reg_req <= '0;
        if (r) #1 chk($sformatf("reg_%h", a), {24'h0, d}, {24'h0, reg_rdata});
    endtask : acc
    // Wait for the target answer; a missing answer is a mismatch
    task automatic wait_done();
        int i;
        for (i = 0; i < 60 && tgt_done !== 1'b1; i++) @(posedge core_clk);
        if (i == 60) begin
            n_fail++;
            $display("CHECK FAILED tgt_done expected 1 seen 0");
        end
        @(posedge core_clk);
    endtask : wait_done
    task automatic end_sim();
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            acc(1, 8'(OFS_IND_CTL + a), a == 7 ? 8'h01 : 8'h00);
        end
        acc(1, 8'h47, 8'h00);
        chk("host_off", 32'h1, {31'h0, id_ram_host_access_off});
        for (int t = 0; t < 4; t++) begin
            lat <= 4'(1 + 3 * t);
            adr = {8'h01, 8'(8'h10 + t)};
            acc(0, OFS_ADDR_HI, adr[15:8]);
            acc(0, OFS_IND_CTL, {3'b000, 2'(t), 3'b101});
            for (int b = 0; b < 4; b++) begin
                acc(0, 8'(OFS_DATA_B0 + b), 8'(8'h11 * (b + 1)));
            end
            if (t < 2) wait_done();
            else repeat (20) @(posedge core_clk);
            acc(0, OFS_ADDR_LO, adr[7:0]);
            acc(0, OFS_IND_CTL, {3'b000, 2'(t), 3'b111});
            wait_done();
            w = (t < 2 ? 32'h4433_2211 : t == 2 ? 32'h5a5a_0000 : 32'h1234_0000) ^ {16'h0, adr};
            for (int b = 0; b < 4; b++) begin
                acc(1, 8'(OFS_DATA_B0 + b), w[8*b +: 8]);
            end
            acc(1, OFS_IND_CTL, {3'b000, 2'(t), 3'b101});
            acc(1, OFS_ADDR_LO, 8'(adr[7:0] + (t == 0 ? 4 : 1)));
        end
        n0 = n_req;
        acc(0, OFS_IND_CTL, 8'h02);
        acc(0, OFS_DATA_B3, 8'h00);
        repeat (20) @(posedge core_clk);
        chk("requests", 32'(n0), 32'(n_req));
        for (int k = 0; k < 3; k++) begin
            acc(0, OFS_BRIDGE, 8'(k << 3));
            @(posedge core_clk);
            #1 chk("cec", 32'(k),
                   {30'h0, cec_timebase_source, cec_timebase_enable});
        end
        acc(0, OFS_BRIDGE, 8'h04);
        acc(1, OFS_BRIDGE, 8'h01);
        chk("clear_go", 32'h0, {31'h0, clr});
        lat <= 4'h8;
        acc(0, OFS_BRIDGE, 8'h06);
        acc(1, OFS_BRIDGE, 8'h07);
        repeat (20) @(posedge core_clk);
        acc(1, OFS_BRIDGE, 8'h01);
        chk("clear_go", 32'h1, {31'h0, clr});
        end_sim();
    end
    // Watchdog
    initial begin
        #(100 * 20000);
        n_fail++;
        end_sim();
    end
endmodule : tb
`default_nettype wire

// File: verification/tgt_model.sv
`timescale 1ns/100ps
`default_nettype none
module tgt_model
    import indirect_bridge_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire tgt_req_s    tgt_req,
    input  wire target_e     tgt_select,
    input  wire logic [3:0]  lat,
    input  wire logic        id_ram_start,
    output var  logic        tgt_done,
    output var  logic [31:0] tgt_rdata,
    output var  logic        id_ram_done
);
    logic [3:0]  cnt = 4'h0;
    logic [3:0]  icnt = 4'h0;
    logic [31:0] mem [4];
    // One word per target; read-only words fixed, writes to them dropped
    always @(posedge core_clk or posedge rst) begin
        if (rst) mem <= '{32'h0, 32'h0, 32'h5a5a_0000, 32'h1234_0000};
        else if (tgt_req.sel && tgt_req.write && !tgt_select[1])
            mem[tgt_select] <= tgt_req.wdata;
    end
    // Answers come lat cycles after a request
    always @(posedge core_clk) begin
        cnt <= rst ? 4'h0 : tgt_req.sel ? lat : cnt - 4'(cnt != 4'h0);
        icnt <= rst ? 4'h0 : id_ram_start ? lat : icnt - 4'(icnt != 4'h0);
    end
    assign tgt_done = cnt == 4'h1;
    assign id_ram_done = icnt == 4'h1;
    // Word only valid with done, else a pattern that moves
    assign tgt_rdata = tgt_done ? mem[tgt_select] ^ {16'h0, tgt_req.addr} : ~{16'h0, tgt_req.addr};
endmodule : tgt_model
`default_nettype wire
